// ===== hw/sar_adc_consts.vh
// Register map, field positions and timing constants of the converter sequencer
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

`define CTRL_OFFSET        4'h0
`define RESULT_OFFSET      4'h4
`define MODE_OFFSET        4'h8

`define DONE_BIT           7
`define RC_SEL_BIT         6
`define POWER_BIT          5
`define SEL_MSB            4
`define SEL_LSB            0

`define CTRL_RESET         8'h00
`define RESULT_RESET       8'h00

`define CONV_CYCLES        32
`define SEL_EXT_LAST       5'h04
`define SEL_HIGH_REF       5'h10
`define SEL_MID_REF        5'h11
`define SEL_LOW_REF        5'h12
`define SEL_RESERVED       5'h13

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== hw/sar_adc_sequencer.v
// Successive-approximation converter sequencer with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "sar_adc_consts.vh"

// Behaviour
// - One conversion takes exactly 32 conversion-clock cycles.
// - Stop mode turns the RC oscillator off; power bit stays set.
// - RC ticks cross into bus clock domain, at most one edge per bus cycle.
// - Done flag is set when a conversion finishes; result is valid.
// - Control write or result read clears the done flag; write restarts.
// - Conversions repeat every 32 cycles once control has been written.
// - Each new result overwrites the previous regardless of done flag.
// - RC select bit switches conversion clock to the RC oscillator.
// - Power bit enables current sources and charge pump.
// - Select codes 00 to 04 choose the five external inputs.
// - Codes 10, 11, 12 route high, mid and low reference.
// - Code 13 and every other unlisted code convert to zero.
// - Low reference gives 00, high gives FF, above saturates.
// - Result register updates together with the done flag.
// - Input sampled at conversion start, then resolved bit by bit.
// - Wait mode does not disturb conversions or the done flag.
// - Stop mode halts conversion and aborts one in progress.
// - Stop mode leaves result and control registers unchanged.
module sar_adc_sequencer (
  // Clock and reset
  input  wire        core_clk,
  input  wire        srst,
  input  wire        clk_en,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Power modes, asynchronous to core_clk
  input  wire        stop_mode,
  input  wire        wait_mode,
  // RC oscillator tick, asynchronous
  input  wire        rc_tick,
  // Analog front end
  output reg  [4:0]  input_select_field,
  output reg         sample_hold,
  output reg  [7:0]  dac_code,
  input  wire        comparator_high,
  output reg         converter_power_on,
  output reg         rc_osc_enable
);

  localparam CNT_W = 5;

  // Sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [1:0] stop_sync;
  reg [1:0] rc_sync;
  reg       rc_prev;
  reg [1:0] cmp_sync;
  reg [1:0] wait_sync;

  always @(posedge core_clk) begin
    if (srst) begin
      wait_sync <= 2'b00;
      stop_sync <= 2'b00;
      rc_sync   <= 2'b00;
      rc_prev   <= 1'b0;
      cmp_sync  <= 2'b00;
    end else if (clk_en) begin
      wait_sync <= {wait_sync[0], wait_mode};
      stop_sync <= {stop_sync[0], stop_mode};
      rc_sync   <= {rc_sync[0], rc_tick};
      rc_prev   <= rc_sync[1];
      cmp_sync  <= {cmp_sync[0], comparator_high};
    end
  end

  wire stopped = stop_sync[1];
  // One RC edge per bus cycle at most
  wire rc_edge = rc_sync[1] & ~rc_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg       rc_clock_select;
  reg       conversion_done_flag;
  reg [7:0] conversion_result;
  reg       restart;

  function is_zero_code;
    input [4:0] sel;
    begin
      is_zero_code = ~((sel <= `SEL_EXT_LAST) | (sel == `SEL_HIGH_REF) |
                       (sel == `SEL_MID_REF) | (sel == `SEL_LOW_REF));
    end
  endfunction

  // Trial bit kept when input at or above the DAC, else dropped
  function [7:0] settle_code;
    input [7:0] code;
    input [7:0] trial;
    input       keep;
    begin
      settle_code = keep ? code : (code & ~trial);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl  = wr_fire & (aw_addr == `CTRL_OFFSET) & w_strb[0];
  wire wr_valid = (aw_addr == `CTRL_OFFSET) | (aw_addr == `RESULT_OFFSET) |
                  (aw_addr == `MODE_OFFSET);
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire rd_res   = ar_take & (s_axi_araddr == `RESULT_OFFSET);

  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_valid ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `CTRL_OFFSET: begin
            s_axi_rdata <= {24'h000000, conversion_done_flag, rc_clock_select,
                            converter_power_on, input_select_field};
          end
          `RESULT_OFFSET: begin
            s_axi_rdata <= {24'h000000, conversion_result};
          end
          `MODE_OFFSET: begin
            s_axi_rdata <= {30'h00000000, wait_sync[1], stopped};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register and RC oscillator enable
  always @(posedge core_clk) begin
    if (srst) begin
      input_select_field <= 5'h00;
      rc_clock_select    <= 1'b0;
      converter_power_on <= 1'b0;
      rc_osc_enable      <= 1'b0;
      restart            <= 1'b0;
    end else if (clk_en) begin
      restart <= wr_ctrl;
      if (wr_ctrl) begin
        input_select_field <= w_data[`SEL_MSB:`SEL_LSB];
        rc_clock_select    <= w_data[`RC_SEL_BIT];
        converter_power_on <= w_data[`POWER_BIT];
      end
      // Oscillator off in stop, power bit untouched
      rc_osc_enable <= rc_clock_select & ~stopped;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  reg [1:0]       state;
  reg [CNT_W-1:0] cycle;
  reg [7:0]       trial_bit;
  reg             running;

  // Conversion clock step: bus clock or RC edge
  wire step = rc_clock_select ? rc_edge : 1'b1;

  always @(posedge core_clk) begin
    if (srst) begin
      state                <= ST_IDLE;
      running              <= 1'b0;
      cycle                <= {CNT_W{1'b0}};
      trial_bit            <= 8'h00;
      dac_code             <= 8'h00;
      sample_hold          <= 1'b0;
      conversion_done_flag <= 1'b0;
      conversion_result    <= `RESULT_RESET;
    end else if (clk_en) begin
      // Clear by control write or result read
      if (wr_ctrl | rd_res) begin
        conversion_done_flag <= 1'b0;
      end
      if (restart) begin
        running     <= 1'b1;
        state       <= ST_CONV;
        cycle       <= {CNT_W{1'b0}};
        trial_bit   <= 8'h80;
        dac_code    <= 8'h80;
        sample_hold <= 1'b1;
      end else if (stopped) begin
        // Abort; registers keep their values
        state       <= ST_IDLE;
        sample_hold <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (running) begin
              state       <= ST_CONV;
              cycle       <= {CNT_W{1'b0}};
              trial_bit   <= 8'h80;
              dac_code    <= 8'h80;
              sample_hold <= 1'b1;
            end
          end
          ST_CONV: begin
            // Wait mode has no effect here
            if (step) begin
              cycle       <= cycle + 1'b1;
              sample_hold <= 1'b0;
              if (cycle[1:0] == 2'b11 && trial_bit != 8'h00) begin
                // Bit decided, keep it if input at or above DAC
                trial_bit <= trial_bit >> 1;
                dac_code  <= settle_code(dac_code, trial_bit, cmp_sync[1]) |
                             (trial_bit >> 1);
              end
              if (cycle == `CONV_CYCLES - 1) begin
                // Load result and set flag together, set wins
                conversion_result    <= is_zero_code(input_select_field) ? 8'h00 :
                                        settle_code(dac_code, trial_bit, cmp_sync[1]);
                conversion_done_flag <= 1'b1;
                cycle                <= {CNT_W{1'b0}};
                trial_bit            <= 8'h80;
                dac_code             <= 8'h80;
                sample_hold          <= 1'b1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // sar_adc_sequencer

// ===== test/sar_adc_props.sv
// Port checker for the converter sequencer
`timescale 1ns/10ps
module sar_adc_props (
  input wire logic        core_clk, srst, stop_mode, sample_hold,
  input wire logic        rc_osc_enable, converter_power_on, s_axi_bvalid, s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [4:0]  input_select_field
);
  logic       dirty;
  logic [5:0] gap;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles since the last sample pulse; dirty marks a disturbed period
  always @(posedge core_clk) begin
    if (srst || sample_hold) begin
      gap   <= 6'h00;
      dirty <= srst || s_axi_bvalid || stop_mode || rc_osc_enable;
    end else begin
      if (gap != 6'h3F) gap <= gap + 6'h01;
      if (s_axi_bvalid || stop_mode || rc_osc_enable) dirty <= 1'b1;
    end
  end
  a_reset_quiet: assert property ($fell(srst) |-> (!sample_hold && !converter_power_on)[*4])
    else $error("activity after reset");
  a_conv_period: assert property (sample_hold && !dirty |-> gap == 6'h1F)
    else $error("conversion period wrong");
  a_sample_pulse: assert property (sample_hold && !rc_osc_enable |=> !sample_hold)
    else $error("sample pulse too long");
  a_stop_rc_off: assert property (stop_mode[*4] |=> !rc_osc_enable)
    else $error("oscillator on in stop");
  a_stop_halts: assert property (stop_mode[*4] |=> !sample_hold)
    else $error("conversion in stop");
  a_stop_keeps: assert property (stop_mode[*4] |=> $stable(converter_power_on))
    else $error("power bit changed in stop");
  a_result_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data set");
  a_select_hold: assert property ($changed(input_select_field) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("select changed without write");
endmodule // sar_adc_props
bind sar_adc_sequencer sar_adc_props u_props (.*);

// ===== test/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "sar_adc_consts.vh"
module tb;
  logic        core_clk=0, srst=1, clk_en=1, stop_mode=0, wait_mode=0, rc_tick=0;
  logic        s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0;
  logic        s_axi_rready=0, comparator_high=0, sample_hold, converter_power_on;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rc_osc_enable;
  logic [3:0]  s_axi_awaddr=0, s_axi_araddr=0, s_axi_wstrb=4'hF;
  logic [31:0] s_axi_wdata=0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  input_select_field;
  logic [7:0]  dac_code, target=0;
  int          errors=0, n_compared=0, cyc=0, i, n;
  // Rows: select, analog level, expected result
  logic [20:0] rows [9] = '{21'h137700, 21'h057700, 21'h147700, 21'h1F7700, 21'h045A5A,
                            21'h10FFFF, 21'h118080, 21'h120000, 21'h00A5A5};
  sar_adc_sequencer DUT (.*);
  initial forever #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    comparator_high <= target >= dac_code;
    rc_tick <= ~rc_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run;
    end
  end
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task poll;
    n = 0;
    do begin
      rd(`CTRL_OFFSET);
      n++;
    end while (d[7] !== 1'b1 && n < 100);
  endtask
  task complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 0;
    rd(`CTRL_OFFSET); chk("ctrl", 0, d);
    rd(`RESULT_OFFSET); chk("result", 0, d);
    for (i = 0; i < 9; i++) begin
      target <= rows[i][15:8];
      wr(`CTRL_OFFSET, {26'h0, 1'b1, rows[i][20:16]}); chk("bresp", `RESP_OKAY, r);
      poll;
      rd(`RESULT_OFFSET);
      poll; chk("ctrl", {24'h0, 3'b101, rows[i][20:16]}, d);
      chk("select", rows[i][20:16], input_select_field);
      rd(`RESULT_OFFSET); chk("result", rows[i][7:0], d);
      rd(`CTRL_OFFSET); chk("done", 0, d[7]);
    end
    n = 0;
    while (sample_hold !== 1'b1 && n < 100) begin @(posedge core_clk); n++; end
    n = 0;
    do begin @(posedge core_clk); n++; end while (sample_hold !== 1'b1 && n < 100);
    chk("period", 32, n);
    wait_mode <= 1; target <= 8'h3C;
    repeat (96) @(posedge core_clk);
    rd(`CTRL_OFFSET); chk("ctrl", 32'hA0, d);
    wr(`RESULT_OFFSET, 32'hFF);
    rd(`RESULT_OFFSET); chk("result", 32'h3C, d);
    rd(4'hC); chk("rresp", `RESP_SLVERR, r);
    wr(`CTRL_OFFSET, 32'h60);
    poll;
    rd(`RESULT_OFFSET);
    chk("rc", 1, rc_osc_enable);
    chk("result", 32'h3C, d);
    stop_mode <= 1;
    repeat (40) @(posedge core_clk);
    chk("rc", 0, rc_osc_enable);
    chk("power", 1, converter_power_on);
    rd(`CTRL_OFFSET); chk("ctrl", 32'h60, d);
    rd(`RESULT_OFFSET); chk("result", 32'h3C, d);
    rd(`MODE_OFFSET); chk("mode", 32'h3, d);
    stop_mode <= 0;
    poll; chk("ctrl", 32'hE0, d);
    wr(`CTRL_OFFSET, 32'h00); repeat (4) @(posedge core_clk); chk("rc", 0, rc_osc_enable);
    complete_run;
  end
endmodule // tb
